// [shared/crcce_pkg.sv]
`default_nettype none

package crcce_pkg;

  // Register byte offsets
  localparam logic [4:0] OFF_CONTROL_MAIN = 5'h00;
  localparam logic [4:0] OFF_LENGTH_CFG   = 5'h04;
  localparam logic [4:0] OFF_ACCUMULATOR  = 5'h08;
  localparam logic [4:0] OFF_TAPS_LOW     = 5'h0C;
  localparam logic [4:0] OFF_TAPS_HIGH    = 5'h10;
  localparam logic [4:0] OFF_WORD_LOW     = 5'h14;
  localparam logic [4:0] OFF_WORD_HIGH    = 5'h18;
  localparam logic [4:0] OFF_DONE_FLAG    = 5'h1C;

  // Control main field positions
  localparam int BIT_ENABLE   = 7;
  localparam int BIT_GO       = 6;
  localparam int BIT_BUSY     = 5;
  localparam int BIT_AUGMENT  = 4;
  localparam int BIT_ORDER    = 1;
  localparam int BIT_FULL     = 0;

  // Length config field positions
  localparam int POS_POLY_LEN = 0;
  localparam int POS_WORD_LEN = 4;
  localparam int LEN_WIDTH    = 4;

  // Done flag position
  localparam int BIT_DONE     = 0;

  // Data widths
  localparam int ACC_WIDTH    = 16;
  localparam int BYTE_WIDTH   = 8;

  // Values after reset
  localparam logic [15:0] RST_ACCUMULATOR = 16'h0000;
  localparam logic [15:0] RST_TAPS        = 16'h0000;
  localparam logic [15:0] RST_WORD        = 16'h0000;
  localparam logic [3:0]  RST_LEN         = 4'h0;

  // Sequencer states
  typedef enum logic [1:0] {
    CRCCE_IDLE,
    CRCCE_SHIFT_DATA,
    CRCCE_SHIFT_ZEROS
  } crcce_state_t;

endpackage

`default_nettype wire

// [hdl/crcce_step.sv]
`default_nettype none

module crcce_step
(
  input  wire logic [15:0] acc,
  input  wire logic [15:0] taps,
  input  wire logic [3:0]  poly_len,
  input  wire logic        in_bit,
  output logic      [15:0] next_acc
);

  logic [15:0] width_mask;
  logic [15:0] poly;
  logic [15:0] shifted;
  logic        out_bit;

  // One serial division step of the feedback register
  always_comb
  begin
    width_mask = 16'hFFFF >> (4'hF - poly_len);
    poly       = {taps[15:1], 1'b1} & width_mask;
    out_bit    = acc[poly_len];
    shifted    = {acc[14:0], in_bit} & width_mask;
    if (out_bit)
    begin
      next_acc = shifted ^ poly;
    end
    else
    begin
      next_acc = shifted;
    end
  end

endmodule

`default_nettype wire

// [hdl/crcce_engine.sv]
`default_nettype none

module crcce_engine
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic [4:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        scan_valid,
  input  wire logic [15:0] scan_data,
  output logic             scan_ready
);

  //////////////////////////////////////////////////////////////////////////
  // Register state

  logic                  enable;
  logic                  go;
  logic                  augment;
  logic                  bit_order;
  logic [3:0]            poly_len;
  logic [3:0]            word_len;
  logic [15:0]           accumulator;
  logic [15:0]           taps;
  logic [7:0]            word_high;
  logic [15:0]           word_buf;
  logic                  full;
  logic                  done_flag;

  // Sequencer state
  crcce_pkg::crcce_state_t state;
  logic [15:0]           shifter;
  logic [3:0]            bit_cnt;
  logic                  busy;
  logic                  busy_q;
  logic                  running;
  logic                  shift_bit;
  logic                  stepping;
  logic [15:0]           next_acc;
  logic                  load_word;

  // Bus handshake
  logic                  ack;
  logic                  wr_fire;
  logic                  be_lo;
  logic                  be_hi;
  logic                  sw_word_wr;
  logic                  scan_take;
  logic [31:0]           next_readdata;

  //////////////////////////////////////////////////////////////////////////
  // Avalon slave handshake

  // Every access waits exactly one cycle
  assign avs_waitrequest = (avs_read | avs_write) & ~ack;
  assign wr_fire         = avs_write & ack;
  assign be_lo           = avs_byteenable[0];
  assign be_hi           = avs_byteenable[1];

  // Acknowledge toggles once per request
  always_ff @(posedge clk)
  begin
    if (rst)
      ack <= 1'b0;
    else
      ack <= (avs_read | avs_write) & ~ack;
  end

  // Read data mux, unmapped reads as zero
  always_comb
  begin
    next_readdata = 32'h0000_0000;
    if (avs_address == crcce_pkg::OFF_CONTROL_MAIN)
    begin
      next_readdata[crcce_pkg::BIT_ENABLE]  = enable;
      next_readdata[crcce_pkg::BIT_GO]      = go;
      next_readdata[crcce_pkg::BIT_BUSY]    = busy;
      next_readdata[crcce_pkg::BIT_AUGMENT] = augment;
      next_readdata[crcce_pkg::BIT_ORDER]   = bit_order;
      next_readdata[crcce_pkg::BIT_FULL]    = full;
    end
    else if (avs_address == crcce_pkg::OFF_LENGTH_CFG)
      next_readdata[7:0] = {word_len, poly_len};
    else if (avs_address == crcce_pkg::OFF_ACCUMULATOR)
      next_readdata[15:0] = accumulator;
    else if (avs_address == crcce_pkg::OFF_TAPS_LOW)
      next_readdata[7:0] = {taps[7:1], 1'b0};
    else if (avs_address == crcce_pkg::OFF_TAPS_HIGH)
      next_readdata[7:0] = taps[15:8];
    else if (avs_address == crcce_pkg::OFF_WORD_LOW)
      next_readdata[7:0] = word_buf[7:0];
    else if (avs_address == crcce_pkg::OFF_WORD_HIGH)
      next_readdata[7:0] = word_high;
    else if (avs_address == crcce_pkg::OFF_DONE_FLAG)
      next_readdata[crcce_pkg::BIT_DONE] = done_flag;
  end

  // Read data registered with the acknowledge
  always_ff @(posedge clk)
  begin
    if (rst)
      avs_readdata <= 32'h0000_0000;
    else if (avs_read & ~ack)
      avs_readdata <= next_readdata;
  end

  //////////////////////////////////////////////////////////////////////////
  // Configuration registers

  // Control and length fields
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      enable    <= 1'b0;
      go        <= 1'b0;
      augment   <= 1'b0;
      bit_order <= 1'b0;
      poly_len  <= crcce_pkg::RST_LEN;
      word_len  <= crcce_pkg::RST_LEN;
    end
    else if (wr_fire & be_lo)
    begin
      if (avs_address == crcce_pkg::OFF_CONTROL_MAIN)
      begin
        enable    <= avs_writedata[crcce_pkg::BIT_ENABLE];
        go        <= avs_writedata[crcce_pkg::BIT_GO];
        augment   <= avs_writedata[crcce_pkg::BIT_AUGMENT];
        bit_order <= avs_writedata[crcce_pkg::BIT_ORDER];
      end
      else if (avs_address == crcce_pkg::OFF_LENGTH_CFG)
      begin
        poly_len <= avs_writedata[crcce_pkg::POS_POLY_LEN +: 4];
        word_len <= avs_writedata[crcce_pkg::POS_WORD_LEN +: 4];
      end
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
      taps <= crcce_pkg::RST_TAPS;
    else if (wr_fire & be_lo)
    begin
      if (avs_address == crcce_pkg::OFF_TAPS_LOW)
        taps[7:0] <= {avs_writedata[7:1], 1'b0};
      else if (avs_address == crcce_pkg::OFF_TAPS_HIGH)
        taps[15:8] <= avs_writedata[7:0];
    end
  end

  // High data byte waits for the low write
  always_ff @(posedge clk)
  begin
    if (rst)
      word_high <= 8'h00;
    else if (wr_fire & be_lo & (avs_address == crcce_pkg::OFF_WORD_HIGH))
      word_high <= avs_writedata[7:0];
  end

  //////////////////////////////////////////////////////////////////////////
  // Data path input

  assign sw_word_wr = wr_fire & be_lo &
                      (avs_address == crcce_pkg::OFF_WORD_LOW);
  assign scan_ready = enable & go & ~full & ~sw_word_wr;
  assign scan_take  = scan_valid & scan_ready;
  assign running    = enable & go;
  assign load_word  = running & full & (state == crcce_pkg::CRCCE_IDLE);

  // Holding word and full indicator
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      word_buf <= crcce_pkg::RST_WORD;
      full     <= 1'b0;
    end
    else if (sw_word_wr)
    begin
      word_buf <= {word_high, avs_writedata[7:0]};
      full     <= 1'b1;
    end
    else if (scan_take)
    begin
      word_buf <= scan_data;
      full     <= 1'b1;
    end
    else if (~enable)
    begin
      full <= 1'b0;
    end
    else if (load_word)
    begin
      full <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Serial sequencer

  always_comb
  begin
    if (state == crcce_pkg::CRCCE_SHIFT_ZEROS)
      shift_bit = 1'b0;
    else if (bit_order)
      shift_bit = shifter[word_len - bit_cnt];
    else
      shift_bit = shifter[bit_cnt];
  end

  assign stepping = running & (state != crcce_pkg::CRCCE_IDLE);

  assign busy = (state != crcce_pkg::CRCCE_IDLE) | (full & running);

  // State, shifter and bit counter
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state   <= crcce_pkg::CRCCE_IDLE;
      shifter <= crcce_pkg::RST_WORD;
      bit_cnt <= 4'h0;
    end
    else if (~enable)
      state <= crcce_pkg::CRCCE_IDLE;
    else if (load_word)
    begin
      shifter <= word_buf;
      bit_cnt <= word_len;
      state   <= crcce_pkg::CRCCE_SHIFT_DATA;
    end
    else if (stepping)
    begin
      case (state)
        crcce_pkg::CRCCE_SHIFT_DATA:
        begin
          if (bit_cnt != 4'h0)
            bit_cnt <= bit_cnt - 4'h1;
          else if (augment & ~full)
          begin
            bit_cnt <= poly_len;
            state   <= crcce_pkg::CRCCE_SHIFT_ZEROS;
          end
          else
            state <= crcce_pkg::CRCCE_IDLE;
        end
        crcce_pkg::CRCCE_SHIFT_ZEROS:
          if (bit_cnt != 4'h0)
            bit_cnt <= bit_cnt - 4'h1;
          else
            state <= crcce_pkg::CRCCE_IDLE;
        default:
          state <= crcce_pkg::CRCCE_IDLE;
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////////
  // Accumulator

  crcce_step crcce_step_inst
  (
    .acc      (accumulator),
    .taps     (taps),
    .poly_len (poly_len),
    .in_bit   (shift_bit),
    .next_acc (next_acc)
  );

  always_ff @(posedge clk)
  begin
    if (rst)
      accumulator <= crcce_pkg::RST_ACCUMULATOR;
    else if (wr_fire & (avs_address == crcce_pkg::OFF_ACCUMULATOR))
    begin
      if (be_lo)
        accumulator[7:0] <= avs_writedata[7:0];
      if (be_hi)
        accumulator[15:8] <= avs_writedata[15:8];
    end
    else if (stepping)
      accumulator <= next_acc;
  end

  //////////////////////////////////////////////////////////////////////////
  // Completion flag

  // set on busy fall, wins over clear
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      busy_q    <= 1'b0;
      done_flag <= 1'b0;
    end
    else
    begin
      busy_q <= busy;
      if (busy_q & ~busy)
        done_flag <= 1'b1;
      else if (wr_fire & be_lo &
               (avs_address == crcce_pkg::OFF_DONE_FLAG) &
               avs_writedata[crcce_pkg::BIT_DONE])
        done_flag <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// [bench/crcce_scanner.sv]
`default_nettype none

module crcce_scanner
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        load,
  input  wire logic [15:0] word,
  input  wire logic [3:0]  gap,
  input  wire logic        scan_ready,
  output logic             scan_valid,
  output logic      [15:0] scan_data,
  output logic             idle
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [15:0] held;
  logic [3:0]  wait_cnt;
  logic        pend;

  // Released bus shows the inverse of the last word
  assign scan_data = scan_valid ? held : ~held;
  assign idle = !pend && !scan_valid;

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      held <= 16'h0000;
      pend <= 1'b0;
      scan_valid <= 1'b0;
    end
    else if (load)
    begin
      held <= word;
      wait_cnt <= gap;
      pend <= 1'b1;
    end
    else if (pend && wait_cnt != 4'h0)
      wait_cnt <= wait_cnt - 4'h1;
    else if (pend)
    begin
      pend <= 1'b0;
      scan_valid <= 1'b1;
    end
    else if (scan_valid && scan_ready)
      scan_valid <= 1'b0;
  end
endmodule

`default_nettype wire

// [bench/crcce_engine_asserts.sv]
`default_nettype none

module crcce_engine_asserts
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [4:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        scan_valid,
  input wire logic [15:0] scan_data,
  input wire logic        scan_ready
);
  timeunit 1ns;
  timeprecision 1ps;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);

  logic rd_done;
  logic go_off;

  // Completed read, control write clearing go
  assign rd_done = avs_read && !avs_waitrequest;
  assign go_off = avs_write && !avs_waitrequest && avs_byteenable[0]
    && avs_address == crcce_pkg::OFF_CONTROL_MAIN
    && !avs_writedata[crcce_pkg::BIT_GO];

  //////////////////////////////
  // Bus handshake steps
  sequence req_rise;
    $rose(avs_read || avs_write);
  endsequence
  sequence one_wait;
    avs_waitrequest ##1 !avs_waitrequest;
  endsequence

  a_one_wait:
    assert property (req_rise |-> one_wait)
    else $error("waitrequest not low one cycle after request");
  a_idle_wait:
    assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest high with no request");
  a_read_holds:
    assert property (!avs_read |=> $stable(avs_readdata))
    else $error("read data moved without a read");
  a_upper_zero:
    assert property (rd_done |-> avs_readdata[31:16] == 16'h0000)
    else $error("read data above sixteen bits not zero");
  a_taps_bit0:
    assert property (rd_done && avs_address == crcce_pkg::OFF_TAPS_LOW
      |-> !avs_readdata[0])
    else $error("taps low bit zero reads one");
  a_take_full:
    assert property (scan_valid && scan_ready |=> !scan_ready)
    else $error("scanner ready right after a word was taken");
  a_go_off:
    assert property (go_off |=> !scan_ready)
    else $error("scanner ready with go cleared");
  a_full_busy:
    assert property (rd_done && avs_address == crcce_pkg::OFF_CONTROL_MAIN
      && avs_readdata[crcce_pkg::BIT_FULL] && avs_readdata[crcce_pkg::BIT_GO]
      && avs_readdata[crcce_pkg::BIT_ENABLE]
      |-> avs_readdata[crcce_pkg::BIT_BUSY])
    else $error("pending word without busy");
  a_reset_clears:
    assert property ($fell(rst) |-> avs_readdata == 32'h0000_0000
      && !scan_ready)
    else $error("outputs not cleared by reset");
endmodule

bind crcce_engine crcce_engine_asserts crcce_engine_asserts_inst
(
  .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
  .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
  .avs_waitrequest(avs_waitrequest), .scan_valid(scan_valid),
  .scan_data(scan_data), .scan_ready(scan_ready)
);

`default_nettype wire

// [bench/tb_crc_checksum_engine.sv]
`default_nettype none

module tb_crc_checksum_engine;
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk;
  logic        rst;
  logic [4:0]  avs_address;
  logic        avs_read;
  logic        avs_write;
  logic [31:0] avs_writedata;
  logic [3:0]  avs_byteenable;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        scan_valid;
  logic [15:0] scan_data;
  logic        scan_ready;
  logic        load;
  logic [15:0] word;
  logic [3:0]  gap;
  logic        idle;
  logic [31:0] q;
  int          miscompares = 0;
  int          cmp_count = 0;
  int          cycles = 0;

  localparam logic [15:0] EN = 16'h0001 << crcce_pkg::BIT_ENABLE;
  localparam logic [15:0] EN_GO = EN | (16'h0001 << crcce_pkg::BIT_GO);
  localparam logic [15:0] AUG = 16'h0001 << crcce_pkg::BIT_AUGMENT;
  localparam logic [15:0] ORD = 16'h0001 << crcce_pkg::BIT_ORDER;
  localparam logic [4:0]  CTL = crcce_pkg::OFF_CONTROL_MAIN;
  localparam logic [4:0]  ACC = crcce_pkg::OFF_ACCUMULATOR;
  localparam logic [4:0]  WLO = crcce_pkg::OFF_WORD_LOW;
  localparam logic [4:0]  WHI = crcce_pkg::OFF_WORD_HIGH;
  localparam logic [4:0]  DONE = crcce_pkg::OFF_DONE_FLAG;
  localparam logic [7:0]  DATA [4] = '{8'h55, 8'h66, 8'h77, 8'h88};

  crcce_engine crcce_engine_inst
  (
    .clk(clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
    .avs_write(avs_write), .avs_writedata(avs_writedata),
    .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .scan_valid(scan_valid),
    .scan_data(scan_data), .scan_ready(scan_ready)
  );

  crcce_scanner crcce_scanner_inst
  (
    .clk(clk), .rst(rst), .load(load), .word(word), .gap(gap),
    .scan_ready(scan_ready), .scan_valid(scan_valid),
    .scan_data(scan_data), .idle(idle)
  );

  // Clock
  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  // Hang guard
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      miscompares++;
      final_report();
    end
  end

  //////////////////////////////
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [4:0] a,
                     input logic [15:0] d, output logic [31:0] r);
    @(posedge clk);
    avs_read <= !w;
    avs_write <= w;
    avs_address <= a;
    avs_writedata <= {16'h0000, d};
    avs_byteenable <= 4'h3;
    @(posedge clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge clk);
    // Answer taken at the edge that sees waitrequest low
    r = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    bus(1'b1, a, d, q);
  endtask

  task automatic rdchk(input logic [4:0] a, input logic [31:0] e);
    bus(1'b0, a, 16'h0000, q);
    check(q, e);
  endtask

  task automatic wait_done();
    int n;
    n = 0;
    q = 32'hFFFF_FFFF;
    while (q[crcce_pkg::BIT_BUSY] !== 1'b0 && n < 100)
    begin
      bus(1'b0, CTL, 16'h0000, q);
      n++;
    end
    check({31'h0, q[crcce_pkg::BIT_BUSY]}, 32'h0000_0000);
  endtask

  task automatic setup(input logic [15:0] ctl, input logic [15:0] len);
    wr(ACC, 16'h0000);
    wr(crcce_pkg::OFF_LENGTH_CFG, len);
    wr(DONE, 16'h0001);
    wr(CTL, ctl);
  endtask

  // next byte only once full clears
  task automatic feed(input logic [7:0] b);
    bus(1'b0, CTL, 16'h0000, q);
    while (q[crcce_pkg::BIT_FULL] !== 1'b0)
      bus(1'b0, CTL, 16'h0000, q);
    wr(WLO, {8'h00, b});
  endtask

  task automatic scan(input logic [15:0] w, input logic [3:0] g);
    @(negedge clk);
    while (idle !== 1'b1)
      @(negedge clk);
    @(posedge clk);
    load <= 1'b1;
    word <= w;
    gap <= g;
    @(posedge clk);
    load <= 1'b0;
  endtask

  //////////////////////////////
  task automatic t_regs();
    for (int a = 0; a < 32; a += 4)
      rdchk(5'(a), 32'h0000_0000);
    wr(CTL, 16'h0021);
    rdchk(CTL, 32'h0000_0000);
    wr(ACC, 16'hA5C3);
    rdchk(ACC, 32'h0000_A5C3);
    wr(crcce_pkg::OFF_TAPS_LOW, 16'h00FF);
    rdchk(crcce_pkg::OFF_TAPS_LOW, 32'h0000_00FE);
    wr(crcce_pkg::OFF_TAPS_LOW, 16'h0004);
    wr(crcce_pkg::OFF_TAPS_HIGH, 16'h0080);
    rdchk(crcce_pkg::OFF_TAPS_HIGH, 32'h0000_0080);
  endtask

  task automatic t_sw_aug();
    setup(EN_GO | AUG, 16'h007F);
    for (int i = 0; i < 4; i++)
      feed(DATA[i]);
    bus(1'b0, CTL, 16'h0000, q);
    check({31'h0, q[crcce_pkg::BIT_BUSY]}, 32'h0000_0001);
    wait_done();
    rdchk(ACC, 32'h0000_32D6);
    rdchk(DONE, 32'h0000_0001);
    wr(DONE, 16'h0001);
    rdchk(DONE, 32'h0000_0000);
  endtask

  task automatic t_check_zero();
    setup(EN_GO, 16'h007F);
    wr(WHI, 16'h00AB);
    rdchk(CTL, {16'h0000, EN_GO});
    for (int i = 0; i < 4; i++)
      feed(DATA[i]);
    wait_done();
    wr(crcce_pkg::OFF_LENGTH_CFG, 16'h00FF);
    wr(WHI, 16'h0032);
    wr(WLO, 16'h00D6);
    wait_done();
    rdchk(ACC, 32'h0000_0000);
  endtask

  task automatic t_scan();
    setup(EN_GO | AUG | ORD, 16'h007F);
    for (int i = 0; i < 4; i++)
      scan({8'hFF, DATA[i]}, i == 0 ? 4'h3 : 4'h0);
    while (idle !== 1'b1)
      @(negedge clk);
    wait_done();
    rdchk(ACC, 32'h0000_6BA2);
  endtask

  task automatic t_reverse();
    wr(crcce_pkg::OFF_TAPS_LOW, 16'h0000);
    wr(crcce_pkg::OFF_TAPS_HIGH, 16'h0000);
    setup(EN_GO | ORD, 16'h00FF);
    wr(WHI, 16'h006B);
    wr(WLO, 16'h00A2);
    wait_done();
    rdchk(ACC, 32'h0000_45D6);
    // Eight-bit width: seed upper byte must vanish
    wr(crcce_pkg::OFF_LENGTH_CFG, 16'h0077);
    wr(CTL, EN_GO);
    wr(ACC, 16'hFF00);
    feed(8'hA5);
    wait_done();
    rdchk(ACC, 32'h0000_00A5);
  endtask

  task automatic t_go_off();
    wr(CTL, EN);
    scan(16'h0055, 4'h0);
    repeat (4) @(posedge clk);
    check({31'h0, scan_valid}, 32'h0000_0001);
    check({31'h0, scan_ready}, 32'h0000_0000);
  endtask

  // Main sequence
  initial
  begin
    rst = 1'b1;
    avs_address = 5'h00;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_writedata = 32'h0000_0000;
    avs_byteenable = 4'h0;
    load = 1'b0;
    word = 16'h0000;
    gap = 4'h0;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    t_regs();
    t_sw_aug();
    t_check_zero();
    t_scan();
    t_reverse();
    t_go_off();
    final_report();
  end
endmodule

`default_nettype wire
